//--- common/dtc_consts.svh
// Register indexes, field positions, reset values and timing counts of the timer block.
`ifndef DTC_CONSTS_SVH
`define DTC_CONSTS_SVH

// ************
// Register indexes (byte address is four times the index)
// ************
`define DTC_IDX_CTRL_STATUS 8'h88
`define DTC_IDX_MODE 8'h89
`define DTC_IDX_T0_LOW 8'h8A
`define DTC_IDX_T1_LOW 8'h8B
`define DTC_IDX_T0_HIGH 8'h8C
`define DTC_IDX_T1_HIGH 8'h8D
`define DTC_IDX_IRQ_STATUS 8'h8E
`define DTC_IDX_IRQ_MASK 8'h8F

// ************
// Control/status register fields
// ************
`define DTC_CS_T1_OVF 7
`define DTC_CS_T1_RUN 6
`define DTC_CS_T0_OVF 5
`define DTC_CS_T0_RUN 4
`define DTC_CS_EXT0_EDGE 1
`define DTC_CS_EXT0_TYPE 0
`define DTC_CS_RESET 8'h00

// ************
// Mode register fields
// ************
`define DTC_MD_T1_MODE_HI 5
`define DTC_MD_T1_MODE_LO 4
`define DTC_MD_GATE 3
`define DTC_MD_CT 2
`define DTC_MD_T0_MODE_HI 1
`define DTC_MD_T0_MODE_LO 0
`define DTC_MD_RESET 6'h00

// ************
// Interrupt status bits and other reset values
// ************
`define DTC_IRQ_T0 0
`define DTC_IRQ_T1 1
`define DTC_IRQ_EXT0 2
`define DTC_IRQ_RESET 3'h0
`define DTC_COUNT_RESET 8'h00

// ************
// Timing
// ************
`define DTC_MC_CLOCKS 6

`endif

//--- common/dtc_pkg.sv
// Types shared by the timer block.
package dtc_pkg;

	typedef enum logic [1:0] {
		DTC_MODE_13BIT = 2'b00,
		DTC_MODE_16BIT = 2'b01,
		DTC_MODE_RELOAD = 2'b10,
		DTC_MODE_SPLIT = 2'b11
	} dtc_mode_t;

	typedef logic [7:0] dtc_byte_t;

endpackage

//--- hw/dtc_timer_counter.sv
// Timer/counter zero with four modes, timer one (timer only, stops in mode 3), external interrupt zero flag and an APB slave.
//
// The APB slave port was decided locally.
`timescale 1ns/1ps
`include "dtc_consts.svh"

module dtc_timer_counter
	import dtc_pkg::*;
#(
	parameter int ADDR_W = 12
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic resetn,
	// APB slave.
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Pins.
	input wire logic timerZeroCountPin,
	input wire logic externalIrqZeroPin,
	// Interrupt service acknowledges.
	input wire logic ackTimerZero,
	input wire logic ackTimerOne,
	input wire logic ackExtIrqZero,
	// Outputs to the system.
	output logic irq,
	output logic timerOneOverflow
);

	initial begin
		if (ADDR_W < 10) begin
			$error("ADDR_W must be at least 10");
		end
	end

	// ************
	// State
	// ************
	logic [2:0] mcCount;
	logic tick;
	logic [2:0] t0Sync;
	logic [2:0] i0Sync;
	logic t0Level;
	logic i0Level;
	logic i0Prev;
	logic t0Sample;
	logic countPend;
	dtc_byte_t tl0;
	dtc_byte_t th0;
	dtc_byte_t tl1;
	dtc_byte_t th1;
	logic [5:0] modeReg;
	logic tf1;
	logic tr1;
	logic tf0;
	logic tr0;
	logic ie0;
	logic it0;
	logic [2:0] irqStatus;
	logic [2:0] irqMask;

	// ************
	// Decode
	// ************
	dtc_mode_t mode0;
	dtc_mode_t mode1;
	logic gate;
	logic countSel;
	logic [7:0] idx;
	logic mapped;
	logic wrEn;
	logic wrByte;
	dtc_byte_t wd;

	assign mode0 = dtc_mode_t'(modeReg[`DTC_MD_T0_MODE_HI:`DTC_MD_T0_MODE_LO]);
	assign mode1 = dtc_mode_t'(modeReg[`DTC_MD_T1_MODE_HI:`DTC_MD_T1_MODE_LO]);
	assign gate = modeReg[`DTC_MD_GATE];
	assign countSel = modeReg[`DTC_MD_CT];
	assign idx = paddr[9:2];
	assign mapped = (paddr[1:0] == 2'h0) && (paddr[ADDR_W-1:10] == '0) &&
		(idx >= `DTC_IDX_CTRL_STATUS) && (idx <= `DTC_IDX_IRQ_MASK);
	assign wrEn = psel && penable && pready && pwrite && !pslverr;
	assign wrByte = wrEn && pstrb[0];
	assign wd = pwdata[7:0];

	// ************
	// Count step
	// ************
	function automatic logic [16:0] next_count(input dtc_mode_t m, input dtc_byte_t hi,
		input dtc_byte_t lo);
		logic [16:0] r;
		r = {1'b0, hi, lo};
		case (m)
			DTC_MODE_13BIT: begin
				r[4:0] = lo[4:0] + 5'h01;
				if (lo[4:0] == 5'h1F) begin
					r[16:8] = {1'b0, hi} + 9'h001;
				end
			end
			DTC_MODE_16BIT: begin
				r = {1'b0, hi, lo} + 17'h00001;
			end
			DTC_MODE_RELOAD: begin
				if (lo == 8'hFF) begin
					r = {1'b1, hi, hi};
				end else begin
					r[7:0] = lo + 8'h01;
				end
			end
			default: begin
				r[16] = (lo == 8'hFF);
				r[7:0] = lo + 8'h01;
			end
		endcase
		return r;
	endfunction

	// ************
	// Machine cycle and pin sampling
	// ************
	assign tick = (mcCount == 3'(`DTC_MC_CLOCKS - 1));

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			mcCount <= 3'h0;
		end else if (tick) begin
			mcCount <= 3'h0;
		end else begin
			mcCount <= mcCount + 3'h1;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			t0Sync <= 3'h0;
			i0Sync <= 3'h7;
			t0Level <= 1'b0;
			i0Level <= 1'b1;
		end else begin
			t0Sync <= {t0Sync[1:0], timerZeroCountPin};
			i0Sync <= {i0Sync[1:0], externalIrqZeroPin};
			if (t0Sync[1] == t0Sync[2]) begin
				t0Level <= t0Sync[2];
			end
			if (i0Sync[1] == i0Sync[2]) begin
				i0Level <= i0Sync[2];
			end
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			t0Sample <= 1'b0;
			countPend <= 1'b0;
		end else if (tick) begin
			t0Sample <= t0Level;
			countPend <= t0Sample && !t0Level;
		end
	end

	// ************
	// Count enables
	// ************
	logic run0;
	logic inc0;
	logic incTh0;
	logic inc1;
	logic [16:0] res0;
	logic [16:0] res1;
	logic setTf0;
	logic setTf1;
	logic ovf1;
	logic extEvent;

	assign run0 = tr0 && (!gate || i0Level);
	assign inc0 = tick && run0 && (!countSel || countPend);
	assign incTh0 = tick && tr1 && (mode0 == DTC_MODE_SPLIT);
	assign inc1 = tick && (mode1 != DTC_MODE_SPLIT) &&
		(tr1 || (mode0 == DTC_MODE_SPLIT));
	assign res0 = next_count(mode0, th0, tl0);
	assign res1 = next_count(mode1, th1, tl1);
	assign setTf0 = inc0 && res0[16];
	assign ovf1 = inc1 && res1[16];
	assign setTf1 = (mode0 == DTC_MODE_SPLIT) ? (incTh0 && th0 == 8'hFF) : ovf1;
	assign extEvent = it0 ? (i0Prev && !i0Level) : !i0Level;

	// ************
	// Count registers
	// ************
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			tl0 <= `DTC_COUNT_RESET;
		end else if (wrByte && idx == `DTC_IDX_T0_LOW) begin
			tl0 <= wd;
		end else if (inc0) begin
			tl0 <= res0[7:0];
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			th0 <= `DTC_COUNT_RESET;
		end else if (wrByte && idx == `DTC_IDX_T0_HIGH) begin
			th0 <= wd;
		end else if (incTh0) begin
			th0 <= th0 + 8'h01;
		end else if (inc0 && mode0 != DTC_MODE_SPLIT) begin
			th0 <= res0[15:8];
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			tl1 <= `DTC_COUNT_RESET;
			th1 <= `DTC_COUNT_RESET;
		end else begin
			if (wrByte && idx == `DTC_IDX_T1_LOW) begin
				tl1 <= wd;
			end else if (inc1) begin
				tl1 <= res1[7:0];
			end
			if (wrByte && idx == `DTC_IDX_T1_HIGH) begin
				th1 <= wd;
			end else if (inc1) begin
				th1 <= res1[15:8];
			end
		end
	end

	// ************
	// Control and mode registers
	// ************
	logic csWr;
	assign csWr = wrByte && idx == `DTC_IDX_CTRL_STATUS;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			modeReg <= `DTC_MD_RESET;
		end else if (wrByte && idx == `DTC_IDX_MODE) begin
			modeReg <= wd[5:0];
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			tr0 <= 1'(`DTC_CS_RESET >> `DTC_CS_T0_RUN);
			tr1 <= 1'(`DTC_CS_RESET >> `DTC_CS_T1_RUN);
			it0 <= 1'(`DTC_CS_RESET >> `DTC_CS_EXT0_TYPE);
		end else if (csWr) begin
			tr0 <= wd[`DTC_CS_T0_RUN];
			tr1 <= wd[`DTC_CS_T1_RUN];
			it0 <= wd[`DTC_CS_EXT0_TYPE];
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			tf0 <= 1'b0;
			tf1 <= 1'b0;
			ie0 <= 1'b0;
			i0Prev <= 1'b1;
		end else begin
			i0Prev <= i0Level;
			if (setTf0) begin
				tf0 <= 1'b1;
			end else if (ackTimerZero) begin
				tf0 <= 1'b0;
			end else if (csWr) begin
				tf0 <= wd[`DTC_CS_T0_OVF];
			end
			if (setTf1) begin
				tf1 <= 1'b1;
			end else if (ackTimerOne) begin
				tf1 <= 1'b0;
			end else if (csWr) begin
				tf1 <= wd[`DTC_CS_T1_OVF];
			end
			if (extEvent) begin
				ie0 <= 1'b1;
			end else if (ackExtIrqZero) begin
				ie0 <= 1'b0;
			end else if (csWr) begin
				ie0 <= wd[`DTC_CS_EXT0_EDGE];
			end
		end
	end

	// ************
	// Interrupt status, mask and output
	// ************
	logic [2:0] irqSet;
	assign irqSet = {extEvent, setTf1, setTf0};

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			irqStatus <= `DTC_IRQ_RESET;
		end else if (wrByte && idx == `DTC_IDX_IRQ_STATUS) begin
			irqStatus <= irqSet | (irqStatus & ~wd[2:0]);
		end else begin
			irqStatus <= irqSet | irqStatus;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			irqMask <= `DTC_IRQ_RESET;
		end else if (wrByte && idx == `DTC_IDX_IRQ_MASK) begin
			irqMask <= wd[2:0];
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			irq <= 1'b0;
			timerOneOverflow <= 1'b0;
		end else begin
			irq <= |(irqStatus & irqMask);
			timerOneOverflow <= ovf1;
		end
	end

	// ************
	// APB answer
	// ************
	logic [7:0] rdByte;

	always_comb begin
		case (idx)
			`DTC_IDX_CTRL_STATUS: rdByte = {tf1, tr1, tf0, tr0, 2'b00, ie0, it0};
			`DTC_IDX_MODE: rdByte = {2'b00, modeReg};
			`DTC_IDX_T0_LOW: rdByte = tl0;
			`DTC_IDX_T1_LOW: rdByte = tl1;
			`DTC_IDX_T0_HIGH: rdByte = th0;
			`DTC_IDX_T1_HIGH: rdByte = th1;
			`DTC_IDX_IRQ_STATUS: rdByte = {5'h00, irqStatus};
			`DTC_IDX_IRQ_MASK: rdByte = {5'h00, irqMask};
			default: rdByte = 8'h00;
		endcase
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
		end else if (psel && penable && !pready) begin
			pready <= 1'b1;
			pslverr <= !mapped;
			prdata <= (mapped && !pwrite) ? {24'h000000, rdByte} : 32'h00000000;
		end else begin
			pready <= 1'b0;
			pslverr <= 1'b0;
		end
	end

endmodule

//--- test/dtc_asserts.sv
// Port checker of the timer block and its bind.
`timescale 1ns/1ps
module dtc_asserts #(
	parameter int ADDR_W = 12
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic resetn,
	// APB.
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// Outputs.
	input wire logic timerOneOverflow
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
	sequence s_wait;
		psel && penable && !pready;
	endsequence
	sequence s_answer;
		pready ##1 !pready;
	endsequence
	chk_one_wait: assert property ($rose(penable) && psel |-> s_wait ##1 s_answer)
		else $error("ready not one wait state");
	chk_ready_req: assert property (pready |-> psel && penable)
		else $error("ready without request");
	chk_err_data: assert property (pslverr |-> pready && prdata == 32'h0)
		else $error("error answer malformed");
	chk_upper_zero: assert property (pready |-> prdata[31:8] == 24'h0)
		else $error("upper read bits not zero");
	chk_write_data: assert property (pready && pwrite |-> prdata == 32'h0)
		else $error("read data on write");
	chk_bad_addr: assert property (pready && paddr[9:2] > 8'h8F |-> pslverr)
		else $error("unmapped address accepted");
	chk_good_addr: assert property (pready && paddr[9:2] >= 8'h88 && paddr[9:2] <= 8'h8F
		&& paddr[1:0] == 2'b00 && paddr[ADDR_W-1:10] == '0 |-> !pslverr)
		else $error("mapped address refused");
	chk_ovf_gap: assert property (timerOneOverflow |=> !timerOneOverflow [*5])
		else $error("overflows closer than a machine cycle");
endmodule
bind dtc_timer_counter dtc_asserts #(.ADDR_W(ADDR_W)) dtc_asserts_inst (.clk, .resetn, .psel,
	.penable, .pwrite, .paddr, .prdata, .pready, .pslverr, .timerOneOverflow);

//--- test/dtc_pins_model.sv
// Behavioural model of the count pin and the gate/interrupt pin.
`timescale 1ns/1ps
module dtc_pins_model (
	// Clock.
	input wire logic clk,
	// Pins.
	output logic countPin,
	output logic gatePin
);
	initial begin
		countPin = 1'b1;
		gatePin = 1'b1;
	end
	// Each level is held for two machine cycles so every level is sampled.
	task automatic pulse(input int n);
		repeat (n) begin
			@(posedge clk) countPin <= 1'b0;
			repeat (12) @(posedge clk);
			countPin <= 1'b1;
			repeat (12) @(posedge clk);
		end
	endtask
	task automatic gate(input logic v);
		@(posedge clk) gatePin <= v;
		repeat (12) @(posedge clk);
	endtask
endmodule

//--- test/tb_top.sv
// Register-level testbench of the timer block.
`timescale 1ns/1ps
`include "dtc_consts.svh"
module tb_top;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [3:0] pstrb = 4'hF;
	logic ack0 = 1'b0;
	logic ack1 = 1'b0;
	logic ackE = 1'b0;
	logic [31:0] prdata;
	logic [31:0] rdata;
	logic pready, pslverr, rerr, cPin, gPin, irq, t1Ovf;
	int mismatches = 0;
	int cmp_count = 0;
	logic t1OvfSeen = 1'b0;
	always #2 clk = ~clk;
	// Remembers that the timer-one overflow pulse was seen.
	always @(posedge clk) begin
		if (t1Ovf === 1'b1) begin
			t1OvfSeen <= 1'b1;
		end
	end
	dtc_timer_counter dtc_timer_counter_inst (.clk, .resetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .pstrb, .prdata, .pready, .pslverr, .timerZeroCountPin(cPin),
		.externalIrqZeroPin(gPin), .ackTimerZero(ack0), .ackTimerOne(ack1),
		.ackExtIrqZero(ackE), .irq, .timerOneOverflow(t1Ovf));
	dtc_pins_model dtc_pins_model_inst (.clk, .countPin(cPin), .gatePin(gPin));
	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic xfer(input logic w, input logic [7:0] idx, input logic [7:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {2'b00, idx, 2'b00};
		pwdata <= {24'h000000, d};
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rdata = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		xfer(1'b1, idx, d);
	endtask
	task automatic rdc(input logic [7:0] idx, input logic [7:0] exp);
		xfer(1'b0, idx, 8'h00);
		chk(rdata, {24'h000000, exp});
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask
	// Loads timer zero, runs it and feeds n falling edges on the count pin.
	task automatic cnt(input logic [7:0] md, lo, hi, input int n, input logic [7:0] cs);
		wr(`DTC_IDX_MODE, md);
		wr(`DTC_IDX_T0_LOW, lo);
		wr(`DTC_IDX_T0_HIGH, hi);
		wr(`DTC_IDX_CTRL_STATUS, 8'h10);
		dtc_pins_model_inst.pulse(n);
		rdc(`DTC_IDX_CTRL_STATUS, cs);
	endtask
	initial begin
		repeat (20000) @(posedge clk);
		mismatches++;
		finish_test();
	end
	initial begin
		cyc(12);
		resetn <= 1'b1;
		xfer(1'b0, `DTC_IDX_CTRL_STATUS, 8'h00);
		chk(rdata, 32'h0);
		cyc(8);
		wr(`DTC_IDX_CTRL_STATUS, 8'h00);
		wr(`DTC_IDX_IRQ_STATUS, 8'h07);
		rdc(`DTC_IDX_MODE, 8'h00);
		xfer(1'b0, 8'h90, 8'h00);
		chk({31'h0, rerr}, 32'h1);
		cnt(8'h04, 8'hFE, 8'hFF, 2, 8'h30);
		rdc(`DTC_IDX_T0_LOW, 8'hE0);
		rdc(`DTC_IDX_T0_HIGH, 8'h00);
		cnt(8'h05, 8'hFF, 8'h12, 1, 8'h10);
		rdc(`DTC_IDX_T0_LOW, 8'h00);
		wr(`DTC_IDX_CTRL_STATUS, 8'h10);
		rdc(`DTC_IDX_T0_HIGH, 8'h13);
		cnt(8'h06, 8'hFF, 8'h80, 1, 8'h30);
		@(posedge clk) ack0 <= 1'b1;
		@(posedge clk) ack0 <= 1'b0;
		rdc(`DTC_IDX_CTRL_STATUS, 8'h10);
		rdc(`DTC_IDX_T0_LOW, 8'h80);
		rdc(`DTC_IDX_T0_HIGH, 8'h80);
		rdc(`DTC_IDX_IRQ_STATUS, 8'h01);
		wr(`DTC_IDX_IRQ_MASK, 8'h01);
		cyc(2);
		chk({31'h0, irq}, 32'h1);
		wr(`DTC_IDX_IRQ_MASK, 8'h04);
		cyc(2);
		chk({31'h0, irq}, 32'h0);
		wr(`DTC_IDX_IRQ_STATUS, 8'h01);
		rdc(`DTC_IDX_IRQ_STATUS, 8'h00);
		dtc_pins_model_inst.gate(1'b0);
		cnt(8'h0D, 8'h00, 8'h00, 2, 8'h12);
		rdc(`DTC_IDX_T0_LOW, 8'h00);
		dtc_pins_model_inst.gate(1'b1);
		wr(`DTC_IDX_CTRL_STATUS, 8'h00);
		rdc(`DTC_IDX_CTRL_STATUS, 8'h00);
		wr(`DTC_IDX_CTRL_STATUS, 8'h01);
		dtc_pins_model_inst.gate(1'b0);
		rdc(`DTC_IDX_CTRL_STATUS, 8'h03);
		@(posedge clk) ackE <= 1'b1;
		@(posedge clk) ackE <= 1'b0;
		rdc(`DTC_IDX_CTRL_STATUS, 8'h01);
		dtc_pins_model_inst.gate(1'b1);
		wr(`DTC_IDX_MODE, 8'h10);
		wr(`DTC_IDX_T1_HIGH, 8'h00);
		wr(`DTC_IDX_T1_LOW, 8'h00);
		wr(`DTC_IDX_CTRL_STATUS, 8'h40);
		cyc(60);
		wr(`DTC_IDX_CTRL_STATUS, 8'h00);
		xfer(1'b0, `DTC_IDX_T1_LOW, 8'h00);
		chk({31'h0, rdata[7:0] >= 8'h09 && rdata[7:0] <= 8'h0C}, 32'h1);
		chk({31'h0, t1OvfSeen}, 32'h0);
		wr(`DTC_IDX_T1_HIGH, 8'hFF);
		wr(`DTC_IDX_T1_LOW, 8'hFF);
		wr(`DTC_IDX_CTRL_STATUS, 8'h40);
		cyc(12);
		rdc(`DTC_IDX_CTRL_STATUS, 8'hC0);
		chk({31'h0, t1OvfSeen}, 32'h1);
		@(posedge clk) ack1 <= 1'b1;
		@(posedge clk) ack1 <= 1'b0;
		rdc(`DTC_IDX_CTRL_STATUS, 8'h40);
		wr(`DTC_IDX_MODE, 8'h30);
		wr(`DTC_IDX_T1_LOW, 8'h00);
		cyc(30);
		rdc(`DTC_IDX_T1_LOW, 8'h00);
		wr(`DTC_IDX_T0_LOW, 8'h55);
		wr(`DTC_IDX_T0_HIGH, 8'hFF);
		wr(`DTC_IDX_MODE, 8'h33);
		cyc(12);
		rdc(`DTC_IDX_CTRL_STATUS, 8'hC0);
		rdc(`DTC_IDX_T0_LOW, 8'h55);
		wr(`DTC_IDX_T0_LOW, 8'hFF);
		wr(`DTC_IDX_CTRL_STATUS, 8'h50);
		cyc(12);
		rdc(`DTC_IDX_CTRL_STATUS, 8'h70);
		wr(`DTC_IDX_CTRL_STATUS, 8'h00);
		wr(`DTC_IDX_MODE, 8'h13);
		cyc(30);
		wr(`DTC_IDX_MODE, 8'h33);
		xfer(1'b0, `DTC_IDX_T1_LOW, 8'h00);
		chk({31'h0, rdata[7:0] >= 8'h05 && rdata[7:0] <= 8'h06}, 32'h1);
		finish_test();
	end
endmodule
